// *** hw/btg_decoder.sv ***
`timescale 1ns/10ps
module btg_decoder
    import btg_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic bundle_valid_i,
    input wire logic [btg_pkg::BUNDLE_W-1:0] bundle_i,
    input wire logic branch_taken_i,
    input wire logic sync_i,
    input wire logic updates_done_i,
    output logic fetch_ready_o,
    output logic issue_valid_o,
    output logic [2:0] slot_valid_o,
    output logic [btg_pkg::SLOT_W-1:0] slot0_o,
    output logic [btg_pkg::SLOT_W-1:0] slot1_o,
    output logic [btg_pkg::SLOT_W-1:0] slot2_o,
    output logic [2:0] unit0_o,
    output logic [2:0] unit1_o,
    output logic [2:0] unit2_o,
    output logic [2:0] stop_o,
    output logic [2:0] group_end_o,
    output logic [1:0] ext_unit_o,
    output logic ext_legacy_o,
    output logic fault_valid_o,
    output logic [1:0] fault_slot_o,
    output logic illegal_tmpl_o,
    output logic group_start_o
);

    // ========================================
    // Bundle split
    logic [TMPL_W-1:0] tmpl;
    logic [SLOT_W-1:0] s0, s1, s2;
    btg_unit_type u0, u1, u2;
    logic [2:0] stops;
    logic undef;
    logic [2:0] ends, flt, leg;
    logic [1:0] ext0, ext1, ext2;
    logic [1:0] first_fault;
    logic [2:0] valid_mask;
    logic [2:0] gend;
    logic sync_wait_reg;
    logic open_group_reg;
    logic pair;

    // Template sits in the lowest bits, i.e. byte 0 of a little-endian
    // bundle.
    assign tmpl = bundle_i[TMPL_LSB +: TMPL_W];
    assign s0 = bundle_i[SLOT0_LSB +: SLOT_W];
    assign s1 = bundle_i[SLOT1_LSB +: SLOT_W];
    assign s2 = bundle_i[SLOT2_LSB +: SLOT_W];

    btg_tmpl_map u_map (
        .tmpl_i(tmpl),
        .unit0_o(u0),
        .unit1_o(u1),
        .unit2_o(u2),
        .stop_o(stops),
        .undef_o(undef)
    );

    btg_slot_class u_c0 (
        .slot_i(s0),
        .unit_i(u0),
        .ends_group_o(ends[0]),
        .fault_o(flt[0]),
        .ext_legacy_o(leg[0]),
        .ext_unit_o(ext0)
    );

    btg_slot_class u_c1 (
        .slot_i(s1),
        .unit_i(u1),
        .ends_group_o(ends[1]),
        .fault_o(flt[1]),
        .ext_legacy_o(leg[1]),
        .ext_unit_o(ext1)
    );

    btg_slot_class u_c2 (
        .slot_i(s2),
        .unit_i(u2),
        .ends_group_o(ends[2]),
        .fault_o(flt[2]),
        .ext_legacy_o(leg[2]),
        .ext_unit_o(ext2)
    );

    // ========================================
    // Earliest fault and slot validity
    // Slots after the first faulting slot are squashed so the earliest
    // exception is the only one reported.
    function automatic logic [1:0] first_set(input logic [2:0] v);
        first_set = v[0] ? 2'h0 : (v[1] ? 2'h1 : 2'h2);
    endfunction : first_set

    always_comb
    begin
        first_fault = first_set(flt);
        valid_mask = 3'b111;
        if (flt[0])
            valid_mask = 3'b001;
        else if (flt[1])
            valid_mask = 3'b011;
        if (undef)
            valid_mask = 3'b000;
    end

    // Group ends at stop or branch-unit fault; other faults do not.
    assign gend = (stops | ends) & valid_mask;

    // Extended pair: slot 2 rides with slot 1, but a stop after the pair
    // must still be seen, so only the slot valid drops it.
    assign pair = (u1 == BTG_UNIT_LONG);

    // ========================================
    // Sync handling: hold fetch until prior updates complete
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            sync_wait_reg <= 1'b0;
        else if (sync_i)
            sync_wait_reg <= 1'b1;
        else if (updates_done_i)
            sync_wait_reg <= 1'b0;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            fetch_ready_o <= 1'b0;
        else
            fetch_ready_o <= !sync_wait_reg && !sync_i;
    end

    // ========================================
    // Group tracking
    // A taken branch closes the open group so target instructions
    // start fresh and never inherit earlier dependencies.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            open_group_reg <= 1'b0;
        else if (branch_taken_i)
            open_group_reg <= 1'b0;
        else if (bundle_valid_i && fetch_ready_o && !undef)
            open_group_reg <= !gend[2] && !flt[0] && !flt[1];
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            group_start_o <= 1'b0;
        else
            group_start_o <= bundle_valid_i && fetch_ready_o
                && !undef && !branch_taken_i && !open_group_reg;
    end

    // ========================================
    // Issue register: one bundle per cycle in fetch order, so the
    // issue stage sees fetch, read, execute, update sequencing.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            issue_valid_o <= 1'b0;
            slot_valid_o <= 3'h0;
            slot0_o <= '0;
            slot1_o <= '0;
            slot2_o <= '0;
            unit0_o <= 3'h0;
            unit1_o <= 3'h0;
            unit2_o <= 3'h0;
            stop_o <= 3'h0;
            group_end_o <= 3'h0;
            ext_unit_o <= 2'h0;
            ext_legacy_o <= 1'b0;
        end
        else
        begin
            issue_valid_o <= bundle_valid_i && fetch_ready_o
                && !undef && !branch_taken_i;
            slot_valid_o <= valid_mask & {!pair, 2'b11};
            // Slots pass whole, predicate field too, for dependency checks
            slot0_o <= s0;
            slot1_o <= s1;
            slot2_o <= s2;
            unit0_o <= u0;
            unit1_o <= u1;
            unit2_o <= u2;
            stop_o <= stops & valid_mask;
            group_end_o <= gend;
            ext_unit_o <= ext2;
            ext_legacy_o <= leg[2];
        end
    end

    // ========================================
    // Fault report
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            fault_valid_o <= 1'b0;
            fault_slot_o <= 2'h0;
            illegal_tmpl_o <= 1'b0;
        end
        else
        begin
            fault_valid_o <= bundle_valid_i && fetch_ready_o
                && !branch_taken_i && (undef || (|flt));
            fault_slot_o <= undef ? 2'h0 : first_fault;
            illegal_tmpl_o <= bundle_valid_i && fetch_ready_o
                && !branch_taken_i && undef;
        end
    end

    // Dependency checking belongs to the issue
    // logic; this block only marks group boundaries for it.

endmodule : btg_decoder

// *** hw/btg_pkg.sv ***
// Contract
// - Bundle is 128 bits: three 41-bit slots, 5-bit template
// - Six instruction types map to unit kinds
// - Template also encodes stop positions
// - Slot-to-unit mapping follows template pair table
// - Eight template values are undefined
// - Extended slot also takes integer break/nop
// - Extended instruction spans two slots, unit by opcode
// - Lower-addressed bundles precede higher ones
// - Little-endian bundle, template in byte 0
// - Slot order within bundle is 0, 1, 2
// - Fetch, read, execute, update in order
// - Group ends at stop, taken branch, branch faults
// - Other breaks, checks, interruptions do not end group
// - Targets never depend on pre-change instructions
// - Fetch unordered; sync forces fetch after updates
// - Next group reads after previous group updates
// - In-group memory reads see earlier in-group updates
// - In-group register reads see pre-group values
// - Dependencies ignore predicated-off instructions
// - Constant true predicate excluded from dependency checks
// - Earliest exception in a group is reported
package btg_pkg;

    // ========================================
    // Bundle layout
    localparam int BUNDLE_W = 128;
    localparam int SLOT_W = 41;
    localparam int TMPL_W = 5;
    localparam int TMPL_LSB = 0;
    localparam int SLOT0_LSB = 5;
    localparam int SLOT1_LSB = 46;
    localparam int SLOT2_LSB = 87;
    localparam int OPC_LSB = 37;
    localparam int OPC_W = 4;
    localparam int QP_W = 6;

    // ========================================
    // Unit kinds
    typedef enum logic [2:0] {
        BTG_UNIT_NONE = 3'h0,
        BTG_UNIT_MEM = 3'h1,
        BTG_UNIT_INT = 3'h2,
        BTG_UNIT_FLT = 3'h3,
        BTG_UNIT_BR = 3'h4,
        BTG_UNIT_LONG = 3'h5,
        BTG_UNIT_EXT = 3'h6
    } btg_unit_type;

    // Branch-unit opcodes of interest in the extended slot
    localparam logic [3:0] OPC_LONG_BR = 4'hc;
    localparam logic [3:0] OPC_LONG_CALL = 4'hd;
    localparam logic [3:0] OPC_MISC = 4'h0;
    // Integer-unit break and nop, and branch-unit break, sub-opcode field
    localparam int X6_LSB = 27;
    localparam logic [5:0] X6_BREAK = 6'h00;
    localparam logic [5:0] X6_NOP = 6'h01;
    localparam logic [5:0] X6_BR_BREAK = 6'h00;
    // Reserved branch-type opcode
    localparam logic [3:0] OPC_BR_RSV = 4'h3;

    // Issue slot unit for extended slot
    localparam logic [1:0] EXT_TO_INT = 2'h1;
    localparam logic [1:0] EXT_TO_BR = 2'h2;

endpackage : btg_pkg

// *** hw/btg_slot_class.sv ***
`timescale 1ns/10ps
module btg_slot_class
    import btg_pkg::*;
(
    input wire logic [btg_pkg::SLOT_W-1:0] slot_i,
    input btg_unit_type unit_i,
    output logic ends_group_o,
    output logic fault_o,
    output logic ext_legacy_o,
    output logic [1:0] ext_unit_o
);

    logic [3:0] opc;
    logic [5:0] x6;

    assign opc = slot_i[OPC_LSB +: OPC_W];
    assign x6 = slot_i[X6_LSB +: 6];

    // ========================================
    // Per-slot group-ending events
    // Only branch-type break and reserved branch encodings end a group;
    // breaks and checks in other units fall through.
    always_comb
    begin
        ends_group_o = 1'b0;
        fault_o = 1'b0;
        ext_legacy_o = 1'b0;
        ext_unit_o = EXT_TO_INT;
        if (unit_i == BTG_UNIT_BR)
        begin
            if (opc == OPC_MISC && x6 == X6_BR_BREAK)
            begin
                ends_group_o = 1'b1;
                fault_o = 1'b1;
            end
            else if (opc == OPC_BR_RSV)
            begin
                ends_group_o = 1'b1;
                fault_o = 1'b1;
            end
        end
        if (unit_i == BTG_UNIT_EXT)
        begin
            if (opc == OPC_LONG_BR || opc == OPC_LONG_CALL)
                ext_unit_o = EXT_TO_BR;
            if (opc == OPC_MISC && (x6 == X6_BREAK || x6 == X6_NOP))
                ext_legacy_o = 1'b1;
        end
    end

endmodule : btg_slot_class

// *** hw/btg_tmpl_map.sv ***
`timescale 1ns/10ps
module btg_tmpl_map
    import btg_pkg::*;
(
    input wire logic [btg_pkg::TMPL_W-1:0] tmpl_i,
    output btg_unit_type unit0_o,
    output btg_unit_type unit1_o,
    output btg_unit_type unit2_o,
    output logic [2:0] stop_o,
    output logic undef_o
);

    // ========================================
    // Template decode
    // Stop encoding: odd defined template stops after slot 2; 02/03, 0a/0b
    // carry a mid stop after slot 1 or 0 respectively.
    always_comb
    begin
        unit0_o = BTG_UNIT_MEM;
        unit1_o = BTG_UNIT_INT;
        unit2_o = BTG_UNIT_INT;
        undef_o = 1'b0;
        stop_o = {tmpl_i[0], 2'b00};
        unique case (tmpl_i[4:1])
            4'h0: ;
            4'h1: stop_o[1] = 1'b1;
            4'h2:
            begin
                unit1_o = BTG_UNIT_LONG;
                unit2_o = BTG_UNIT_EXT;
            end
            4'h4: unit1_o = BTG_UNIT_MEM;
            4'h5:
            begin
                unit1_o = BTG_UNIT_MEM;
                stop_o[0] = 1'b1;
            end
            4'h6: unit1_o = BTG_UNIT_FLT;
            4'h7:
            begin
                unit1_o = BTG_UNIT_MEM;
                unit2_o = BTG_UNIT_FLT;
            end
            4'h8: unit2_o = BTG_UNIT_BR;
            4'h9:
            begin
                unit1_o = BTG_UNIT_BR;
                unit2_o = BTG_UNIT_BR;
            end
            4'hb:
            begin
                unit0_o = BTG_UNIT_BR;
                unit1_o = BTG_UNIT_BR;
                unit2_o = BTG_UNIT_BR;
            end
            4'hc:
            begin
                unit1_o = BTG_UNIT_MEM;
                unit2_o = BTG_UNIT_BR;
            end
            4'he:
            begin
                unit1_o = BTG_UNIT_FLT;
                unit2_o = BTG_UNIT_BR;
            end
            default:
            begin
                unit0_o = BTG_UNIT_NONE;
                unit1_o = BTG_UNIT_NONE;
                unit2_o = BTG_UNIT_NONE;
                stop_o = 3'h0;
                undef_o = 1'b1;
            end
        endcase
    end

endmodule : btg_tmpl_map

// *** sim/btg_decoder_asserts.sv ***
`timescale 1ns/10ps
module btg_decoder_asserts
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic bundle_valid_i,
    input wire logic [127:0] bundle_i,
    input wire logic branch_taken_i,
    input wire logic sync_i,
    input wire logic fetch_ready_o,
    input wire logic issue_valid_o,
    input wire logic [2:0] slot_valid_o,
    input wire logic [40:0] slot0_o,
    input wire logic [2:0] unit1_o,
    input wire logic [2:0] stop_o,
    input wire logic [2:0] group_end_o,
    input wire logic fault_valid_o,
    input wire logic illegal_tmpl_o
);
    // ========================================
    // Checks
    logic take;
    logic undef;
    assign take = bundle_valid_i && fetch_ready_o && !branch_taken_i;
    assign undef = bundle_i[4:0] inside {5'h06, 5'h07, 5'h14, 5'h15,
        5'h1a, 5'h1b, 5'h1e, 5'h1f};

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_take_def;
        take && !undef;
    endsequence
    sequence s_take_undef;
        take && undef;
    endsequence

    a_issue_next: assert property (s_take_def |=> issue_valid_o)
        else $error("defined bundle not issued");
    a_undef_fault: assert property (s_take_undef |=> illegal_tmpl_o
        && !issue_valid_o && slot_valid_o == 3'h0)
        else $error("undefined template not refused");
    a_slot_split: assert property (s_take_def |=>
        slot0_o == $past(bundle_i[45:5]))
        else $error("slot 0 taken from wrong bits");
    a_stop_odd: assert property (issue_valid_o && !fault_valid_o |->
        stop_o[2] == $past(bundle_i[0]))
        else $error("stop after slot 2 wrong");
    a_end_at_stop: assert property (issue_valid_o |->
        (group_end_o & stop_o) == stop_o)
        else $error("stop without group end");
    a_long_pair: assert property (s_take_def ##0
        bundle_i[4:1] == 4'h2 |=> unit1_o == 3'h5 && !slot_valid_o[2])
        else $error("long pair not one instruction");
    a_branch_drop: assert property (bundle_valid_i && branch_taken_i
        |=> !issue_valid_o)
        else $error("bundle issued beside taken branch");
    a_sync_hold: assert property (sync_i |=> !fetch_ready_o)
        else $error("fetch not held after sync");
endmodule : btg_decoder_asserts

bind btg_decoder btg_decoder_asserts btg_decoder_asserts_inst (
    .clock_i(clock_i), .resetn_i(resetn_i),
    .bundle_valid_i(bundle_valid_i), .bundle_i(bundle_i),
    .branch_taken_i(branch_taken_i), .sync_i(sync_i),
    .fetch_ready_o(fetch_ready_o), .issue_valid_o(issue_valid_o),
    .slot_valid_o(slot_valid_o), .slot0_o(slot0_o), .unit1_o(unit1_o),
    .stop_o(stop_o), .group_end_o(group_end_o),
    .fault_valid_o(fault_valid_o),
    .illegal_tmpl_o(illegal_tmpl_o));

// *** sim/btg_decoder_test.sv ***
`timescale 1ns/10ps
module btg_decoder_test;
    import btg_pkg::*;
    // ========================================
    // Harness
    logic clock_i = 0, resetn_i = 0, bundle_valid_i = 0;
    logic branch_taken_i = 0, sync_i = 0, updates_done_i;
    logic [127:0] bundle_i = 0;
    logic fetch_ready_o, issue_valid_o, ext_legacy_o, fault_valid_o;
    logic illegal_tmpl_o, group_start_o;
    logic [2:0] slot_valid_o, unit0_o, unit1_o, unit2_o, stop_o, group_end_o;
    logic [40:0] slot0_o, slot1_o, slot2_o;
    logic [1:0] ext_unit_o, fault_slot_o;
    int err_count = 0, n_tests = 0, cycles = 0;

    btg_decoder btg_decoder_inst (.clock_i(clock_i), .resetn_i(resetn_i),
        .bundle_valid_i(bundle_valid_i), .bundle_i(bundle_i),
        .branch_taken_i(branch_taken_i), .sync_i(sync_i),
        .updates_done_i(updates_done_i), .fetch_ready_o(fetch_ready_o),
        .issue_valid_o(issue_valid_o), .slot_valid_o(slot_valid_o),
        .slot0_o(slot0_o), .slot1_o(slot1_o), .slot2_o(slot2_o),
        .unit0_o(unit0_o), .unit1_o(unit1_o), .unit2_o(unit2_o),
        .stop_o(stop_o), .group_end_o(group_end_o), .ext_unit_o(ext_unit_o),
        .ext_legacy_o(ext_legacy_o), .fault_valid_o(fault_valid_o),
        .fault_slot_o(fault_slot_o), .illegal_tmpl_o(illegal_tmpl_o),
        .group_start_o(group_start_o));
    btg_exec_model #(.DELAY(5)) btg_exec_model_inst (.clock_i(clock_i),
        .resetn_i(resetn_i), .sync_i(sync_i),
        .updates_done_o(updates_done_i));

    initial forever #4 clock_i = ~clock_i;
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            err_count++;
            results();
        end
    end

    task automatic results;
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic send(input logic [127:0] b, input logic br);
        @(posedge clock_i);
        bundle_valid_i <= 1'b1;
        bundle_i <= b;
        branch_taken_i <= br;
        @(posedge clock_i);
        bundle_valid_i <= 1'b0;
        branch_taken_i <= 1'b0;
        #1;
    endtask : send

    function automatic logic [40:0] mk(input logic [3:0] op,
        input logic [5:0] x6);
        return {op, 4'h0, x6, 27'h0};
    endfunction : mk

    // Units per template pair, zero where the template is undefined
    function automatic logic [8:0] exp_map(input logic [4:0] t);
        case (t[4:1])
            4'h0, 4'h1: return {3'h1, 3'h2, 3'h2};
            4'h2: return {3'h1, 3'h5, 3'h6};
            4'h4, 4'h5: return {3'h1, 3'h1, 3'h2};
            4'h6: return {3'h1, 3'h3, 3'h2};
            4'h7: return {3'h1, 3'h1, 3'h3};
            4'h8: return {3'h1, 3'h2, 3'h4};
            4'h9: return {3'h1, 3'h4, 3'h4};
            4'hb: return {3'h4, 3'h4, 3'h4};
            4'hc: return {3'h1, 3'h1, 3'h4};
            4'he: return {3'h1, 3'h3, 3'h4};
            default: return 9'h0;
        endcase
    endfunction : exp_map

    // ========================================
    // Scenarios
    task automatic t_layout;
        send({mk(4'h7, 6'h3), mk(4'h6, 6'h2), mk(4'h5, 6'h1), 5'h00}, 0);
        chk(slot2_o, mk(4'h7, 6'h3));
        chk(slot1_o, mk(4'h6, 6'h2));
        chk(slot0_o, mk(4'h5, 6'h1));
        chk(slot_valid_o, 3'h7);
        chk(group_start_o, 1'b1);
    endtask : t_layout

    task automatic t_templates;
        logic [40:0] s;
        logic [4:0] t;
        s = mk(4'h4, 6'h3);
        for (int i = 0; i < 32; i++)
        begin
            t = i[4:0];
            send({s, s, s, t}, 1'b0);
            chk(issue_valid_o, exp_map(t) != 0);
            chk(illegal_tmpl_o, exp_map(t) == 0);
            if (exp_map(t) != 0)
            begin
                chk({unit0_o, unit1_o, unit2_o}, exp_map(t));
                chk(stop_o, {t[0], t[4:1] == 4'h1, t[4:1] == 4'h5});
                chk(group_end_o, stop_o);
            end
        end
    endtask : t_templates

    task automatic t_faults;
        logic [40:0] n;
        n = mk(4'h4, 6'h3);
        send({n, n, mk(4'h0, 6'h0), 5'h16}, 0);
        chk({fault_valid_o, fault_slot_o}, 3'h4);
        chk({group_end_o[0], slot_valid_o[2:1]}, 3'h4);
        send({mk(4'h0, 6'h0), mk(4'h3, 6'h0), n, 5'h16}, 0);
        chk({fault_valid_o, fault_slot_o}, 3'h5);
        send({n, mk(4'h0, 6'h0), n, 5'h00}, 0);
        chk({fault_valid_o, group_end_o, slot_valid_o}, 7'h07);
        send({n, n, n, 5'h00}, 0);
        chk(group_start_o, 1'b0);
    endtask : t_faults

    task automatic t_ext;
        logic [40:0] n;
        n = mk(4'h4, 6'h3);
        send({mk(4'hc, 6'h3), n, n, 5'h04}, 0);
        chk(ext_unit_o, EXT_TO_BR);
        send({mk(4'h6, 6'h3), n, n, 5'h05}, 0);
        chk(ext_unit_o, EXT_TO_INT);
        send({mk(4'h0, 6'h1), n, n, 5'h04}, 0);
        chk({issue_valid_o, ext_legacy_o}, 2'h3);
    endtask : t_ext

    task automatic t_branch;
        logic [40:0] n;
        n = mk(4'h4, 6'h3);
        send({n, n, n, 5'h00}, 1);
        chk({issue_valid_o, group_start_o}, 2'h0);
        send({n, n, n, 5'h00}, 0);
        chk(group_start_o, 1'b1);
    endtask : t_branch

    task automatic t_sync;
        int n;
        @(posedge clock_i);
        sync_i <= 1'b1;
        @(posedge clock_i);
        sync_i <= 1'b0;
        #1;
        chk(fetch_ready_o, 1'b0);
        n = 0;
        while (fetch_ready_o !== 1'b1 && n < 40)
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk({fetch_ready_o, n >= 4}, 2'h3);
    endtask : t_sync

    initial
    begin
        repeat (6) @(posedge clock_i);
        chk({fetch_ready_o, issue_valid_o}, 2'h0);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        t_layout();
        t_templates();
        t_faults();
        t_ext();
        t_branch();
        t_sync();
        results();
    end
endmodule : btg_decoder_test

// *** sim/btg_exec_model.sv ***
`timescale 1ns/10ps
module btg_exec_model
#(
    parameter int DELAY = 5
)
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic sync_i,
    output logic updates_done_o
);
    // ========================================
    // Update drain
    // Fixed drain time, long enough that a held fetch is visible
    int count_reg;

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            count_reg <= 0;
            updates_done_o <= 1'b0;
        end
        else
        begin
            updates_done_o <= (count_reg == 1);
            if (sync_i)
                count_reg <= DELAY;
            else if (count_reg != 0)
                count_reg <= count_reg - 1;
        end
    end
endmodule : btg_exec_model
